/* File: logic/clkgen_defines.svh */
// Constants of the strap-selected CPU clock generator
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// Strap patterns sampled at the end of reset
`define CLKGEN_STRAP_X4      3'h7
`define CLKGEN_STRAP_X3      3'h6
`define CLKGEN_STRAP_X2      3'h5
`define CLKGEN_STRAP_X5      3'h4
`define CLKGEN_STRAP_DIRECT  3'h3
`define CLKGEN_STRAP_X1P5    3'h2
`define CLKGEN_STRAP_PRESC   3'h1
`define CLKGEN_STRAP_X2P5    3'h0

// Mode held during reset, the default configuration
`define CLKGEN_RESET_MODE    3'h7

// Half-periods of the CPU clock per input period (twice the factor)
`define CLKGEN_HALVES_X4     4'h8
`define CLKGEN_HALVES_X3     4'h6
`define CLKGEN_HALVES_X2     4'h4
`define CLKGEN_HALVES_X5     4'hA
`define CLKGEN_HALVES_X1P5   4'h3
`define CLKGEN_HALVES_X2P5   4'h5
`define CLKGEN_HALVES_X1     4'h2

// Input transitions between two resynchronisations
`define CLKGEN_SYNC_X4       3'h4
`define CLKGEN_SYNC_X3       3'h3
`define CLKGEN_SYNC_X2       3'h2
`define CLKGEN_SYNC_X5       3'h5
`define CLKGEN_SYNC_X1P5     3'h2
`define CLKGEN_SYNC_X2P5     3'h3

// Oscillator watchdog overflows on its 16th free-running PLL clock
`define CLKGEN_WDOG_LAST     5'h0F

`endif

/* File: logic/clkgen_pkg.sv */
// Types shared by the CPU clock generator
package clkgen_pkg;

    // Source of the CPU clock
    typedef enum logic [1:0]
    {
        SRC_PLL     = 2'b00,
        SRC_DIRECT  = 2'b01,
        SRC_PRESC   = 2'b10,
        SRC_FREERUN = 2'b11
    } clk_src_t;

    // Status carried out of the generator
    typedef struct packed
    {
        logic       pll_on;
        logic       wdog_fail;
        logic [1:0] source;
        logic [2:0] mode;
    } clk_status_t;

endpackage

/* File: logic/pll_ratio_nco.sv */
// Fractional tick generator standing in for the multiplying PLL
`timescale 1ns/1ps
`include "clkgen_defines.svh"

module pll_ratio_nco
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // Control
    input  wire logic       enable_i,
    input  wire logic       trans_i,
    input  wire logic [3:0] halves_i,
    input  wire logic [2:0] sync_i,
    // Half-period tick
    output logic            tick_o
);

    logic [CNT_W-1:0] win_cnt_q;
    logic [2:0]       trans_cnt_q;
    logic [CNT_W:0]   thr_q;
    logic [CNT_W:0]   acc_q;
    logic             tick_q;
    logic [6:0]       step;
    logic [CNT_W+1:0] sum;

    generate
        if (CNT_W < 8)
        begin : g_chk
            $error("pll_ratio_nco: CNT_W too small");
        end
    endgenerate

    // Phase step per cycle in units where one window equals twice its length
    assign step = 7'(halves_i) * 7'(sync_i);
    assign sum  = (CNT_W+2)'(acc_q) + (CNT_W+2)'(step);
    assign tick_o = tick_q;

    // Measure the window of sync_i input transitions; saturate on a stall
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            win_cnt_q   <= '0;
            trans_cnt_q <= 3'h0;
            thr_q       <= '0;
        end
        else if (!enable_i)
        begin
            win_cnt_q   <= '0;
            trans_cnt_q <= 3'h0;
            thr_q       <= '0;
        end
        else if (trans_i && (trans_cnt_q + 3'h1 >= sync_i))
        begin
            // Only the target moves, the phase is kept, so no abrupt step
            thr_q       <= {win_cnt_q + CNT_W'(1), 1'b0};
            win_cnt_q   <= '0;
            trans_cnt_q <= 3'h0;
        end
        else
        begin
            if (~&win_cnt_q)
            begin
                win_cnt_q <= win_cnt_q + CNT_W'(1);
            end
            if (trans_i)
            begin
                trans_cnt_q <= trans_cnt_q + 3'h1;
            end
        end
    end

    // Accumulate phase; one toggle per threshold crossing
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (!enable_i || thr_q == '0)
        begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (sum >= (CNT_W+2)'(thr_q))
        begin
            acc_q  <= (CNT_W+1)'(sum - (CNT_W+2)'(thr_q));
            tick_q <= 1'b1;
        end
        else
        begin
            acc_q  <= (CNT_W+1)'(sum);
            tick_q <= 1'b0;
        end
    end

endmodule

/* File: logic/reset_strapped_clock_generation.sv */
// CPU clock generator with strap-selected mode and oscillator watchdog
//
// Overview of operation
// - Clock mode chosen from straps on the first edge after reset release
// - Eight strap patterns map to clock ratios
// - Pattern 001 selects divide-by-two prescaler
// - Prescaler: each phase one input period
// - Prescaler keeps PLL free-running unless disabled
// - Watchdog disable bit switches PLL off in direct and prescaler modes
// - Pattern 011 drives CPU clock directly
// - Direct drive follows input frequency and duty
// - Direct drive: half-period pair equals period
// - Every CPU clock edge marks half-period
// - Other patterns multiply via PLL, smooth resync
// - Watchdog enabled after reset, disable bit
// - Watchdog overflows after 16 clocks, flags
// - After failure stay on PLL until reset
`timescale 1ns/1ps
`include "clkgen_defines.svh"

module reset_strapped_clock_generation
#(
    parameter int CNT_W    = 16,
    parameter int FREE_DIV = 8
)
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    // Oscillator input and straps
    input  wire logic                    crystal_input_pin_i,
    input  wire logic [2:0]              clock_mode_strap_pins_i,
    // Watchdog disable, bit 4 of the system configuration register
    input  wire logic                    osc_watchdog_disable_i,
    // CPU clock side
    output logic                         cpu_clk_o,
    output logic                         clock_half_period_o,
    output logic                         osc_watchdog_irq_flag_o,
    output clkgen_pkg::clk_status_t      status_o
);
    import clkgen_pkg::*;

    logic        done_q;
    logic [2:0]  mode_q;
    clk_src_t    src_q;
    logic        xtal_q;
    logic        rise;
    logic        trans;
    logic [7:0]  div_q;
    logic        pll_tick;
    logic        pll_on_q;
    logic        wd_active;
    logic [4:0]  wd_cnt_q;
    logic        wd_ovf;
    logic        fail_q;
    logic        irq_q;
    logic        cpu_clk_q;
    logic        cpu_clk_d;
    logic        half_q;
    logic        nco_tick;
    clk_status_t status_q;

    generate
        if (FREE_DIV < 2 || FREE_DIV > 256)
        begin : g_chk
            $error("clock generator: FREE_DIV out of range");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Strap decode
    // ----------------------------------------------------------------

    // Clock source selected by a strap pattern
    function automatic clk_src_t decode_src(input logic [2:0] strap);
        case (strap)
            `CLKGEN_STRAP_DIRECT: decode_src = SRC_DIRECT;
            `CLKGEN_STRAP_PRESC:  decode_src = SRC_PRESC;
            default:              decode_src = SRC_PLL;
        endcase
    endfunction

    // Twice the multiplication factor for the PLL patterns
    function automatic logic [3:0] ratio_halves(input logic [2:0] strap);
        case (strap)
            `CLKGEN_STRAP_X4:   ratio_halves = `CLKGEN_HALVES_X4;
            `CLKGEN_STRAP_X3:   ratio_halves = `CLKGEN_HALVES_X3;
            `CLKGEN_STRAP_X2:   ratio_halves = `CLKGEN_HALVES_X2;
            `CLKGEN_STRAP_X5:   ratio_halves = `CLKGEN_HALVES_X5;
            `CLKGEN_STRAP_X1P5: ratio_halves = `CLKGEN_HALVES_X1P5;
            `CLKGEN_STRAP_X2P5: ratio_halves = `CLKGEN_HALVES_X2P5;
            default:            ratio_halves = `CLKGEN_HALVES_X1;
        endcase
    endfunction

    // Input transitions per resynchronisation, factor rounded up
    function automatic logic [2:0] sync_count(input logic [2:0] strap);
        case (strap)
            `CLKGEN_STRAP_X4:   sync_count = `CLKGEN_SYNC_X4;
            `CLKGEN_STRAP_X3:   sync_count = `CLKGEN_SYNC_X3;
            `CLKGEN_STRAP_X2:   sync_count = `CLKGEN_SYNC_X2;
            `CLKGEN_STRAP_X5:   sync_count = `CLKGEN_SYNC_X5;
            `CLKGEN_STRAP_X1P5: sync_count = `CLKGEN_SYNC_X1P5;
            default:            sync_count = `CLKGEN_SYNC_X2P5;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Mode capture
    // ----------------------------------------------------------------

    // Straps are caught on the first edge after release, never again;
    // an async-reset flop may not load a port value
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mode_q <= `CLKGEN_RESET_MODE;
            done_q <= 1'b0;
        end
        else if (!done_q)
        begin
            mode_q <= clock_mode_strap_pins_i;
            done_q <= 1'b1;
        end
    end

    // Source register; the failover is one-way until hardware reset
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            src_q <= SRC_PLL;
        end
        else if (!done_q)
        begin
            src_q <= decode_src(clock_mode_strap_pins_i);
        end
        else if (wd_ovf)
        begin
            src_q <= SRC_FREERUN;
        end
    end

    // ----------------------------------------------------------------
    // Input edges and free-running PLL
    // ----------------------------------------------------------------

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            xtal_q <= 1'b0;
        end
        else
        begin
            xtal_q <= crystal_input_pin_i;
        end
    end

    assign rise  = crystal_input_pin_i & ~xtal_q;
    assign trans = crystal_input_pin_i ^ xtal_q;

    // Free-running PLL clock, one tick every FREE_DIV cycles while on
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            div_q <= 8'h00;
        end
        else if (!pll_on_q || div_q == 8'(FREE_DIV - 1))
        begin
            div_q <= 8'h00;
        end
        else
        begin
            div_q <= div_q + 8'h01;
        end
    end

    assign pll_tick = pll_on_q && (div_q == 8'(FREE_DIV - 1));

    // PLL power: off in the direct modes whenever the watchdog is disabled
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pll_on_q <= 1'b0;
        end
        else
        begin
            case (src_q)
                SRC_PLL:     pll_on_q <= done_q;
                SRC_FREERUN: pll_on_q <= 1'b1;
                SRC_DIRECT:  pll_on_q <= !osc_watchdog_disable_i;
                SRC_PRESC:   pll_on_q <= !osc_watchdog_disable_i;
                default:     pll_on_q <= 1'b0;
            endcase
        end
    end

    pll_ratio_nco
    #(
        .CNT_W      (CNT_W)
    )
    u_nco
    (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .enable_i   (done_q && src_q == SRC_PLL),
        .trans_i    (trans),
        .halves_i   (ratio_halves(mode_q)),
        .sync_i     (sync_count(mode_q)),
        .tick_o     (nco_tick)
    );

    // ----------------------------------------------------------------
    // Oscillator watchdog
    // ----------------------------------------------------------------

    // Enabled from reset because the disable input defaults low on the board
    assign wd_active = done_q && !osc_watchdog_disable_i
                       && (src_q == SRC_DIRECT || src_q == SRC_PRESC);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wd_cnt_q <= 5'h00;
        end
        else if (!wd_active || trans)
        begin
            wd_cnt_q <= 5'h00;
        end
        else if (pll_tick)
        begin
            wd_cnt_q <= wd_cnt_q + 5'h01;
        end
    end

    assign wd_ovf = wd_active && !trans && pll_tick
                    && (wd_cnt_q == `CLKGEN_WDOG_LAST);

    // Failure and its flag stay until hardware reset; nothing else clears
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fail_q <= 1'b0;
            irq_q  <= 1'b0;
        end
        else if (wd_ovf)
        begin
            fail_q <= 1'b1;
            irq_q  <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // CPU clock
    // ----------------------------------------------------------------

    // Direct drive copies the input one cycle late, keeping duty and period
    always_comb
    begin
        cpu_clk_d = cpu_clk_q;
        if (done_q)
        begin
            case (src_q)
                SRC_DIRECT:  cpu_clk_d = crystal_input_pin_i;
                SRC_PRESC:   cpu_clk_d = rise ? ~cpu_clk_q : cpu_clk_q;
                SRC_PLL:     cpu_clk_d = nco_tick ? ~cpu_clk_q : cpu_clk_q;
                SRC_FREERUN: cpu_clk_d = pll_tick ? ~cpu_clk_q : cpu_clk_q;
                default:     cpu_clk_d = cpu_clk_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cpu_clk_q <= 1'b0;
            half_q    <= 1'b0;
            status_q  <= '0;
        end
        else
        begin
            cpu_clk_q <= cpu_clk_d;
            half_q    <= cpu_clk_d ^ cpu_clk_q;
            status_q  <= '{pll_on: pll_on_q, wdog_fail: fail_q,
                           source: src_q, mode: mode_q};
        end
    end

    assign cpu_clk_o               = cpu_clk_q;
    assign clock_half_period_o     = half_q;
    assign osc_watchdog_irq_flag_o = irq_q;
    assign status_o                = status_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_strap_mode_held: assert property (
        done_q && $past(done_q) |-> $stable(mode_q) && $stable(done_q))
        else $error("clock mode changed after capture");
    a_strap_src_map: assert property (
        !done_q |=> done_q && src_q == decode_src($past(clock_mode_strap_pins_i)))
        else $error("source not taken from straps");
    a_presc_toggle: assert property (
        src_q == SRC_PRESC && done_q && rise |=> cpu_clk_q != $past(cpu_clk_q))
        else $error("prescaler missed an input rise");
    a_presc_phase: assert property (
        src_q == SRC_PRESC && done_q && !rise |=> $stable(cpu_clk_q))
        else $error("prescaler phase shorter than input period");
    a_pll_free_run: assert property (
        src_q == SRC_PRESC && !osc_watchdog_disable_i |=> pll_on_q)
        else $error("PLL off while watchdog enabled");
    a_pll_off_dis: assert property (
        (src_q == SRC_PRESC || src_q == SRC_DIRECT) && osc_watchdog_disable_i
        |=> !pll_on_q ##1 !pll_tick)
        else $error("PLL still on while watchdog disabled");
    a_direct_follow: assert property (
        src_q == SRC_DIRECT && done_q |=> cpu_clk_q == $past(crystal_input_pin_i))
        else $error("direct clock does not follow input");
    a_pll_mode_on: assert property (
        src_q == SRC_PLL && done_q |=> pll_on_q)
        else $error("PLL off in multiply mode");
    a_half_tick: assert property (
        half_q == (cpu_clk_q != $past(cpu_clk_q)))
        else $error("half-period tick not on clock edge");
    a_wdog_overflow: assert property (
        wd_active && !trans && pll_tick && wd_cnt_q == 5'h0F
        |=> fail_q && irq_q ##1 src_q == SRC_FREERUN && osc_watchdog_irq_flag_o)
        else $error("watchdog overflow not acted on");
    a_wdog_clear: assert property (
        wd_active && trans |=> wd_cnt_q == 5'h00)
        else $error("watchdog not cleared by input transition");
    a_fail_sticky: assert property (
        fail_q |=> fail_q && src_q == SRC_FREERUN && pll_on_q)
        else $error("clock left free-running source before reset");

    c_direct_mode: cover property (src_q == SRC_DIRECT && half_q);
    c_presc_mode:  cover property (src_q == SRC_PRESC && half_q);
    c_pll_mode:    cover property (src_q == SRC_PLL && half_q);
    c_failover:    cover property ($rose(fail_q));

endmodule

/* File: tb/tb.sv */
// Self-checking bench for the strap-selected CPU clock generator
`timescale 1ns/1ps
`include "clkgen_defines.svh"

module tb;
    import clkgen_pkg::*;

    // ----------------------------------------
    // Signals and bench state
    // ----------------------------------------
    localparam int FREE_DIV = 4;
    localparam int MAX_CYC  = 20000;
    // Half-periods per input period, indexed by strap pattern
    localparam logic [7:0] HALVES [8] = '{8'h05, 8'h00, 8'h03, 8'h02,
                                          8'h0A, 8'h04, 8'h06, 8'h08};
    typedef struct packed
    {
        logic       level;
        logic [7:0] len;
    } half_note_t;

    logic        clk_i       = 1'b0;
    logic        resetn_i    = 1'b0;
    logic [2:0]  strap_pins  = 3'h7;
    logic        wdog_dis    = 1'b0;
    logic        xtal_run    = 1'b0;
    logic [7:0]  xtal_hi     = 8'h03;
    logic [7:0]  xtal_lo     = 8'h03;
    logic        xtal;
    logic        cpu_clk;
    logic        half_pulse;
    logic        irq;
    clk_status_t status;
    int          mismatches  = 0;
    int          tests_run   = 0;
    int          cycles      = 0;
    int          pulses      = 0;
    integer      seed        = 32'h8347d05a;
    logic [31:0] rnd;
    logic        chk_en      = 1'b0;
    logic        direct_mode = 1'b0;
    logic        first_pulse = 1'b1;
    logic        xtal_prev   = 1'b0;
    logic        cpu_exp     = 1'b0;
    logic [7:0]  since_edge  = 8'h00;
    logic [7:0]  since_pulse = 8'h00;
    half_note_t  note_q[$];
    half_note_t  push_n;
    half_note_t  pop_n;

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    reset_strapped_clock_generation #(.CNT_W(16), .FREE_DIV(FREE_DIV)) dut
    (
        .clk_i                   (clk_i),
        .resetn_i                (resetn_i),
        .crystal_input_pin_i     (xtal),
        .clock_mode_strap_pins_i (strap_pins),
        .osc_watchdog_disable_i  (wdog_dis),
        .cpu_clk_o               (cpu_clk),
        .clock_half_period_o     (half_pulse),
        .osc_watchdog_irq_flag_o (irq),
        .status_o                (status)
    );

    xtal_source_model osc
    (
        .clk_i         (clk_i),
        .run_i         (xtal_run),
        .high_cycles_i (xtal_hi),
        .low_cycles_i  (xtal_lo),
        .xtal_o        (xtal)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Reset with a strap pattern; straps are scrambled after capture
    task automatic start(input logic [2:0] strap, input logic dis);
        @(negedge clk_i);
        chk_en     = 1'b0;
        xtal_run   = 1'b0;
        resetn_i   = 1'b0;
        strap_pins = strap;
        wdog_dis   = dis;
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rnd        = $random(seed);
        strap_pins = rnd[2:0];
        repeat (3) @(negedge clk_i);
        check("mode", 8'(status.mode), 8'(strap));
    endtask

    task automatic arm(input logic direct);
        note_q.delete();
        direct_mode = direct;
        cpu_exp     = 1'b0;
        first_pulse = 1'b1;
        chk_en      = 1'b1;
    endtask

    // Random duty cycle, 2..9 cycles per phase
    task automatic drive_xtal(input int n);
        rnd      = $random(seed);
        xtal_hi  = {5'h00, rnd[2:0]} + 8'h02;
        xtal_lo  = {5'h00, rnd[5:3]} + 8'h02;
        xtal_run = 1'b1;
        repeat (n * 18) @(negedge clk_i);
    endtask

    // ----------------------------------------
    // Recorder and monitor
    // ----------------------------------------
    // Notes each expected CPU clock half at the input transition causing it
    always @(posedge clk_i)
    begin
        since_edge = since_edge + 8'h01;
        if (chk_en && xtal !== xtal_prev && (direct_mode || xtal))
        begin
            cpu_exp = direct_mode ? xtal : ~cpu_exp;
            push_n  = '{cpu_exp, since_edge};
            note_q.push_back(push_n);
            since_edge = 8'h00;
        end
        xtal_prev = xtal;
    end

    // Takes the oldest note at each half-period pulse
    always @(negedge clk_i)
    begin
        since_pulse = since_pulse + 8'h01;
        if (half_pulse === 1'b1)
            pulses++;
        if (chk_en && half_pulse === 1'b1)
        begin
            if (note_q.size() == 0)
                check("stray edge", 8'h01, 8'h00);
            else
            begin
                pop_n = note_q.pop_front();
                check("cpu level", 8'(cpu_clk), 8'(pop_n.level));
                if (!first_pulse)
                    check("half length", since_pulse, pop_n.len);
                first_pulse = 1'b0;
            end
            since_pulse = 8'h00;
        end
    end

    // Hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == MAX_CYC)
        begin
            mismatches++;
            summarize();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        // Direct drive, then oscillator loss
        start(`CLKGEN_STRAP_DIRECT, 1'b0);
        check("src", 8'(status.source), 8'(SRC_DIRECT));
        check("pll on", 8'(status.pll_on), 8'h01);
        check("irq reset", 8'(irq), 8'h00);
        arm(1'b1);
        drive_xtal(8);
        drive_xtal(8);
        chk_en = 1'b0;
        check("halves seen", 8'(pulses > 20), 8'h01);
        xtal_run = 1'b0;
        // The last input edge may lie a full phase before the stop, hence the margins
        repeat (12 * FREE_DIV) @(negedge clk_i);
        check("irq early", 8'(irq), 8'h00);
        repeat (6 * FREE_DIV) @(negedge clk_i);
        check("irq", 8'(irq), 8'h01);
        check("failover", 8'(status.source), 8'(SRC_FREERUN));
        check("fail flag", 8'(status.wdog_fail), 8'h01);
        drive_xtal(4);
        check("no return", 8'(status.source), 8'(SRC_FREERUN));
        check("irq held", 8'(irq), 8'h01);
        // Direct drive with watchdog off: PLL off, a dead input is not flagged
        start(`CLKGEN_STRAP_DIRECT, 1'b1);
        check("pll off", 8'(status.pll_on), 8'h00);
        repeat (24 * FREE_DIV) @(negedge clk_i);
        check("no irq", 8'(irq), 8'h00);
        // Prescaler with watchdog off: PLL off, no failover
        start(`CLKGEN_STRAP_PRESC, 1'b1);
        check("src", 8'(status.source), 8'(SRC_PRESC));
        check("pll off", 8'(status.pll_on), 8'h00);
        arm(1'b0);
        drive_xtal(10);
        drive_xtal(10);
        chk_en   = 1'b0;
        xtal_run = 1'b0;
        repeat (24 * FREE_DIV) @(negedge clk_i);
        check("no irq", 8'(irq), 8'h00);
        check("stay presc", 8'(status.source), 8'(SRC_PRESC));
        // Prescaler, watchdog on, then disabled at run time
        start(`CLKGEN_STRAP_PRESC, 1'b0);
        check("pll free", 8'(status.pll_on), 8'h01);
        wdog_dis = 1'b1;
        repeat (3) @(negedge clk_i);
        check("pll off", 8'(status.pll_on), 8'h00);
        // Every multiplying pattern
        foreach (HALVES[s])
        begin
            if (s != 1 && s != 3)
            begin
                rnd = $random(seed);
                start(3'(s), rnd[0]);
                check("src", 8'(status.source), 8'(SRC_PLL));
                check("pll on", 8'(status.pll_on), 8'h01);
                xtal_hi  = 8'h18;
                xtal_lo  = 8'h18;
                xtal_run = 1'b1;
                repeat (8 * 48) @(negedge clk_i);
                @(posedge xtal);
                pulses = 0;
                repeat (4 * 48) @(negedge clk_i);
                check("ratio", 8'(pulses >= 4 * HALVES[s] - 1 && pulses <= 4 * HALVES[s] + 1),
                      8'h01);
            end
        end
        summarize();
    end
endmodule

/* File: tb/xtal_source_model.sv */
// Behavioural external clock source feeding the crystal input
`timescale 1ns/1ps

module xtal_source_model
(
    // Bench clock and control
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [7:0] high_cycles_i,
    input  wire logic [7:0] low_cycles_i,
    // Oscillator output
    output logic            xtal_o
);
    logic [7:0] phase_cnt;

    initial
    begin
        xtal_o    = 1'b0;
        phase_cnt = 8'h01;
    end

    // Phase counter; a stopped source sits low, as a dead oscillator would
    always @(negedge clk_i)
    begin
        if (!run_i)
        begin
            xtal_o    <= 1'b0;
            phase_cnt <= 8'h01;
        end
        else if (phase_cnt >= (xtal_o ? high_cycles_i : low_cycles_i))
        begin
            xtal_o    <= ~xtal_o;
            phase_cnt <= 8'h01;
        end
        else
            phase_cnt <= phase_cnt + 8'h01;
    end
endmodule
